// *** hdl/cam_decoder.v ***
// addressing mode decoder and load/store engine of the core
// assumes asynchronous-read program memory and data space; writes land on the edge
`include "cam_regs.vh"

module cam_decoder (
   // clock and reset
   input wire CLOCK_IN,
   input wire RST_N_IN,
   // program memory
   output reg [11:0] PM_ADDR_OUT,
   input wire [7:0] PM_DATA_IN,
   // data space
   output reg [7:0] DS_ADDR_OUT,
   output reg DS_RD_OUT,
   output reg DS_WR_OUT,
   output reg [7:0] DS_WDATA_OUT,
   input wire [7:0] DS_RDATA_IN,
   // interrupt entry
   input wire INT_REQ_IN,
   input wire [11:0] INT_VEC_IN,
   output reg INT_ACK_OUT,
   // core state
   output reg [11:0] PC_OUT,
   output reg [7:0] ACC_OUT,
   output reg CARRY_OUT,
   output reg ZERO_OUT,
   output reg INSTR_DONE_OUT
);
   localparam [4:0] P0 = 5'h01;
   localparam [4:0] P1 = 5'h02;
   localparam [4:0] P2 = 5'h04;
   localparam [4:0] P3 = 5'h08;
   localparam [4:0] P4 = 5'h10;

   reg [4:0] state_r;
   reg [7:0] op_r;
   reg [7:0] b2_r;
   reg [7:0] b3_r;
   reg btb_take_r;
   reg [7:0] sd_r [0:3];

   // opcode classes
   wire is_rel = (op_r[7] == `CAM_REL_FLAG);
   wire is_jmp = (op_r[7:4] == `CAM_OP_JMP);
   wire is_call = (op_r[7:4] == `CAM_OP_CALL);
   wire is_bset = (op_r[7:3] == `CAM_OP_BSET);
   wire is_bclr = (op_r[7:3] == `CAM_OP_BCLR);
   wire is_btb = (op_r[7:4] == `CAM_OP_BTB);
   wire is_ldsd = (op_r[7:2] == `CAM_OP_LDSD);
   wire is_stsd = (op_r[7:2] == `CAM_OP_STSD);
   wire is_lddir = (op_r == `CAM_OP_LDDIR);
   wire is_stdir = (op_r == `CAM_OP_STDIR);
   wire is_ldia = (op_r == `CAM_OP_LDIA);
   wire is_ldir = (op_r == `CAM_OP_LDIR);
   wire is_ldind = ((op_r & `CAM_IND_MASK) == `CAM_OP_LDIND);
   wire is_stind = ((op_r & `CAM_IND_MASK) == `CAM_OP_STIND);
   wire is_ret = (op_r == `CAM_OP_RET);
   wire is_bitop = is_bset | is_bclr;
   wire is_ind = is_ldind | is_stind;
   wire is_sd = is_ldsd | is_stsd;
   wire is_ldst = is_sd | is_lddir | is_stdir | is_ldia | is_ldir | is_ind;
   wire is_store = is_stsd | is_stdir | is_stind;
   wire is_dsrd = is_lddir | is_ldind | is_bitop | is_btb;
   // RULE12 anything unlisted is one-byte inherent
   wire is_inh = ~(is_rel | is_jmp | is_call | is_bitop | is_btb | is_ldst);

   // RULE13 byte length per mode
   wire len3 = is_btb | is_ldir;
   wire len2 = is_jmp | is_call | is_bitop | is_lddir | is_stdir | is_ldia;
   wire [11:0] len = len3 ? `CAM_LEN3 : (len2 ? `CAM_LEN2 : `CAM_LEN1);

   // RULE15 four cycles for load/store, five for bit test, two for one-byte flow
   wire [4:0] last_st = is_btb ? P4 : ((is_rel | is_ret | is_inh) ? P1 : P3);
   wire fin = (state_r == last_st);

   // data address: second byte arrives during P1 and is held afterwards
   wire [7:0] b2_src = (state_r == P1) ? PM_DATA_IN : b2_r;
   // RULE11 pointer chosen by opcode bit 4
   wire [7:0] ptr = op_r[`CAM_PTR_SEL_BIT] ? sd_r[1] : sd_r[0];
   // RULE4 short-direct from opcode bits only
   wire [7:0] sd_addr = {`CAM_SHORT_BASE, op_r[1:0]};
   // RULE3 direct byte reaches all of data space
   wire [7:0] daddr = is_ind ? ptr : (is_sd ? sd_addr : b2_src);
   wire ehit = (daddr[7:2] == `CAM_SHORT_BASE);
   wire [7:0] rd_val = ehit ? sd_r[daddr[1:0]] : DS_RDATA_IN;
   wire tbit = rd_val[op_r[2:0]];
   wire [7:0] bmask = `CAM_BIT_ONE << op_r[2:0];
   // RULE8 set or clear the opcode's bit
   wire [7:0] bit_mod = is_bset ? (rd_val | bmask) : (rd_val & ~bmask);

   wire [11:0] rel_tgt;
   wire [11:0] ext_tgt;
   wire [11:0] bt_tgt;
   wire [11:0] stk_top;

   cam_target_calc u_tgt (
      .pc_in(PC_OUT),
      .op_in(op_r),
      .b2_in(b2_r),
      .disp_in(b3_r),
      .rel_tgt_out(rel_tgt),
      .ext_tgt_out(ext_tgt),
      .bt_tgt_out(bt_tgt)
   );

   // relative test
   reg rel_cond;
   always @* begin
      case (op_r[7:5])
         `CAM_TST_C1: rel_cond = CARRY_OUT;
         `CAM_TST_C0: rel_cond = ~CARRY_OUT;
         `CAM_TST_Z1: rel_cond = ZERO_OUT;
         `CAM_TST_Z0: rel_cond = ~ZERO_OUT;
         default: rel_cond = 1'b0;
      endcase
   end

   // next pc
   wire [11:0] seq_pc = PC_OUT + len;
   reg [11:0] npc_base;
   always @* begin
      npc_base = seq_pc;
      if (is_jmp | is_call) begin
         npc_base = ext_tgt;
      end else if (is_rel & rel_cond) begin
         npc_base = rel_tgt;
      end else if (is_btb & btb_take_r) begin
         npc_base = bt_tgt;
      end else if (is_ret) begin
         npc_base = stk_top;
      end
   end
   wire take_int = fin & INT_REQ_IN & ~is_call & ~is_ret;
   wire [11:0] npc = take_int ? INT_VEC_IN : npc_base;

   // RULE1 calls and interrupts push, return pops
   wire push = fin & (is_call | take_int);
   wire pop = fin & is_ret;
   wire [11:0] push_data = is_call ? seq_pc : npc_base;

   cam_ret_stack u_stk (
      .clk_in(CLOCK_IN),
      .rst_n_in(RST_N_IN),
      .push_in(push),
      .pop_in(pop),
      .push_data_in(push_data),
      .top_out(stk_top)
   );

   integer k;
   always @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         state_r <= P0;
         op_r <= `CAM_ZERO8;
         b2_r <= `CAM_ZERO8;
         b3_r <= `CAM_ZERO8;
         btb_take_r <= 1'b0;
         for (k = 0; k < 4; k = k + 1) begin
            sd_r[k] <= `CAM_ZERO8;
         end
         PM_ADDR_OUT <= `CAM_PC_RST;
         PC_OUT <= `CAM_PC_RST;
         DS_ADDR_OUT <= `CAM_ZERO8;
         DS_RD_OUT <= 1'b0;
         DS_WR_OUT <= 1'b0;
         DS_WDATA_OUT <= `CAM_ZERO8;
         INT_ACK_OUT <= 1'b0;
         ACC_OUT <= `CAM_ZERO8;
         CARRY_OUT <= 1'b0;
         ZERO_OUT <= 1'b0;
         INSTR_DONE_OUT <= 1'b0;
      end else begin
         DS_RD_OUT <= 1'b0;
         DS_WR_OUT <= 1'b0;
         INT_ACK_OUT <= 1'b0;
         INSTR_DONE_OUT <= 1'b0;
         case (state_r)
            P0: begin
               op_r <= PM_DATA_IN;
               PM_ADDR_OUT <= PC_OUT + `CAM_LEN1;
               state_r <= P1;
            end
            P1: begin
               // RULE2 immediate byte follows the opcode
               b2_r <= PM_DATA_IN;
               PM_ADDR_OUT <= PC_OUT + `CAM_LEN2;
               state_r <= P2;
               // RULE14 accumulator to data space
               if (is_store) begin
                  if (ehit) begin
                     sd_r[daddr[1:0]] <= ACC_OUT;
                  end else begin
                     DS_ADDR_OUT <= daddr;
                     DS_WR_OUT <= 1'b1;
                     DS_WDATA_OUT <= ACC_OUT;
                  end
                  ZERO_OUT <= (ACC_OUT == `CAM_ZERO8);
               end else if (is_dsrd & ~ehit) begin
                  DS_ADDR_OUT <= daddr;
                  DS_RD_OUT <= 1'b1;
               end
            end
            P2: begin
               state_r <= P3;
               b3_r <= PM_DATA_IN;
               // RULE14 data space to accumulator
               if (is_lddir | is_ldind | is_ldsd) begin
                  ACC_OUT <= rd_val;
                  ZERO_OUT <= (rd_val == `CAM_ZERO8);
               end
               if (is_ldia) begin
                  ACC_OUT <= b2_r;
                  ZERO_OUT <= (b2_r == `CAM_ZERO8);
               end
               // RULE15 immediate-to-register keeps zero flag
               if (is_ldir | is_bitop) begin
                  if (ehit) begin
                     sd_r[daddr[1:0]] <= is_ldir ? PM_DATA_IN : bit_mod;
                  end else begin
                     DS_ADDR_OUT <= daddr;
                     DS_WR_OUT <= 1'b1;
                     DS_WDATA_OUT <= is_ldir ? PM_DATA_IN : bit_mod;
                  end
               end
               // RULE10 tested bit into carry
               if (is_bitop | is_btb) begin
                  CARRY_OUT <= tbit;
               end
               // RULE9 branch sense in opcode bit 3
               btb_take_r <= (tbit == op_r[`CAM_SENSE_BIT]);
            end
            P3: begin
               state_r <= P4;
            end
            P4: begin
               state_r <= P0;
            end
            default: begin
               state_r <= P0;
            end
         endcase
         // RULE16 advance by length or load target
         if (fin) begin
            PC_OUT <= npc;
            PM_ADDR_OUT <= npc;
            state_r <= P0;
            INSTR_DONE_OUT <= 1'b1;
            INT_ACK_OUT <= take_int;
         end
      end
   end
endmodule

// *** hdl/cam_ret_stack.v ***
// six-entry return stack, newest entry on top
// assumes push and pop are never asserted together
`include "cam_regs.vh"

module cam_ret_stack (
   input wire clk_in,
   input wire rst_n_in,
   input wire push_in,
   input wire pop_in,
   input wire [11:0] push_data_in,
   output wire [11:0] top_out
);
   reg [11:0] ent_r [0:`CAM_STACK_DEPTH-1];

   // RULE1 shifting return slots
   genvar i;
   generate
      for (i = 0; i < `CAM_STACK_DEPTH; i = i + 1) begin : g_ent
         always @(posedge clk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               ent_r[i] <= `CAM_ZERO12;
            end else if (push_in) begin
               ent_r[i] <= (i == 0) ? push_data_in : ent_r[(i == 0) ? 0 : i - 1];
            end else if (pop_in) begin
               ent_r[i] <= (i == `CAM_STACK_DEPTH - 1) ? `CAM_ZERO12 :
                           ent_r[(i == `CAM_STACK_DEPTH - 1) ? i : i + 1];
            end
         end
      end
   endgenerate

   assign top_out = ent_r[0];
endmodule

// *** hdl/cam_target_calc.v ***
// branch and jump target arithmetic
// assumes pc is the address of the instruction's opcode
`include "cam_regs.vh"

module cam_target_calc (
   input wire [11:0] pc_in,
   input wire [7:0] op_in,
   input wire [7:0] b2_in,
   input wire [7:0] disp_in,
   output wire [11:0] rel_tgt_out,
   output wire [11:0] ext_tgt_out,
   output wire [11:0] bt_tgt_out
);
   wire [11:0] span = {8'h00, op_in[3:0]};

   // RULE6 direction bit picks add or subtract
   // RULE7 forward reaches +16, backward -15
   assign rel_tgt_out = op_in[`CAM_DIR_BIT] ? (pc_in - span) : (pc_in + span + `CAM_LEN1);

   // RULE5 low nibble joined to next byte
   assign ext_tgt_out = {op_in[3:0], b2_in};

   // RULE9 signed displacement -127..+128
   assign bt_tgt_out = pc_in + {{4{disp_in[7]}}, disp_in} + `CAM_LEN1;
endmodule

// *** pkg/cam_regs.vh ***
// constants for the addressing mode decoder and its load/store engine
// assumes program memory and data space answer combinationally to held addresses
//
// What this block does
// RULE1: six-entry return stack of 12-bit addresses for calls and interrupts
// RULE2: immediate operand is the program byte right after the opcode
// RULE3: direct mode uses the next byte as 8-bit data address, two bytes
// RULE4: short-direct picks one of registers 80h-83h from opcode bits, one byte
// RULE5: extended jump/call target is opcode low nibble joined to next byte
// RULE6: relative opcode: test type, direction bit, four-bit span added or subtracted
// RULE7: taken relative branch reaches -15..+16, else next instruction follows
// RULE8: bit-direct sets or clears opcode bit number in byte at next address
// RULE9: bit-test branch is three bytes: opcode, tested address, displacement -127..+128
// RULE10: bit set and bit clear copy the addressed bit into carry
// RULE11: indirect mode addresses through pointer at 80h or 81h, chosen by bit 4
// RULE12: inherent instructions are one byte, opcode alone
// RULE13: load/store length is one, two or three bytes by addressing mode
// RULE14: loads and stores move accumulator to/from data space; immediate may reach any byte
// RULE15: load/store take 4 cycles, carry kept, zero updated except immediate-to-register
// RULE16: program counter advances by instruction length unless a target is loaded
`ifndef CAM_REGS_VH
`define CAM_REGS_VH

// reset values
`define CAM_PC_RST 12'h000
`define CAM_ZERO8 8'h00
`define CAM_ZERO12 12'h000
`define CAM_BIT_ONE 8'h01

// instruction lengths
`define CAM_LEN1 12'h001
`define CAM_LEN2 12'h002
`define CAM_LEN3 12'h003

// short-direct block at 80h..83h, seen as address[7:2]
`define CAM_SHORT_BASE 6'h20
`define CAM_STACK_DEPTH 6

// opcode map, field positions
`define CAM_REL_FLAG 1'b0
`define CAM_OP_JMP 4'h8
`define CAM_OP_CALL 4'h9
`define CAM_OP_BSET 5'h14
`define CAM_OP_BCLR 5'h15
`define CAM_OP_BTB 4'hb
`define CAM_OP_LDSD 6'h30
`define CAM_OP_STSD 6'h31
`define CAM_OP_LDDIR 8'hc8
`define CAM_OP_STDIR 8'hc9
`define CAM_OP_LDIA 8'hca
`define CAM_OP_LDIR 8'hcb
`define CAM_IND_MASK 8'hef
`define CAM_OP_LDIND 8'he0
`define CAM_OP_STIND 8'he1
`define CAM_OP_RET 8'he8
`define CAM_PTR_SEL_BIT 4
`define CAM_DIR_BIT 4
`define CAM_SENSE_BIT 3

// relative test types
`define CAM_TST_C1 3'h0
`define CAM_TST_C0 3'h1
`define CAM_TST_Z1 3'h2
`define CAM_TST_Z0 3'h3

`endif

// *** verif/cam_decoder_props.sv ***
// timing and address checks on the decoder ports
// assumes the opcode is on the program bus while done is high
`include "cam_regs.vh"
module cam_decoder_props (
   input wire CLOCK_IN,
   input wire RST_N_IN,
   input wire [11:0] PM_ADDR_OUT,
   input wire [7:0] PM_DATA_IN,
   input wire [7:0] DS_ADDR_OUT,
   input wire DS_RD_OUT,
   input wire DS_WR_OUT,
   input wire [11:0] INT_VEC_IN,
   input wire INT_ACK_OUT,
   input wire [11:0] PC_OUT,
   input wire CARRY_OUT,
   input wire ZERO_OUT,
   input wire INSTR_DONE_OUT
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RST_N_IN);
   function automatic logic [11:0] op_len(input logic [7:0] op);
      if (op == `CAM_OP_LDIR) return `CAM_LEN3;
      if (op[3]) return `CAM_LEN2;
      return `CAM_LEN1;
   endfunction
   sequence s_fetch;
      INSTR_DONE_OUT && PM_ADDR_OUT == PC_OUT;
   endsequence
   sequence s_ldst;
      s_fetch ##0 ((PM_DATA_IN[7:4] == 4'hc && PM_DATA_IN[3:2] != 2'h3)
         || (PM_DATA_IN & `CAM_IND_MASK) == `CAM_OP_LDIND || (PM_DATA_IN & `CAM_IND_MASK) == `CAM_OP_STIND);
   endsequence
   sequence s_four;
      !INSTR_DONE_OUT [*3] ##1 INSTR_DONE_OUT;
   endsequence
   a_ldst_four_cyc:
      assert property (s_ldst |=> s_four) else $error("load/store not four cycles");
   a_ldst_carry_kept:
      assert property (s_ldst |=> $stable(CARRY_OUT) [*4]) else $error("carry changed by load/store");
   a_ldir_zero_kept:
      assert property (s_fetch ##0 PM_DATA_IN == `CAM_OP_LDIR |=> $stable(ZERO_OUT) [*4])
         else $error("zero changed by immediate-to-register");
   a_ldst_length:
      assert property (s_ldst |-> ##4 PC_OUT == $past(PC_OUT, 4) + op_len($past(PM_DATA_IN, 4)))
         else $error("wrong load/store length");
   a_jump_target:
      assert property (s_fetch ##0 PM_DATA_IN[7:4] == `CAM_OP_JMP
         |-> ##4 PC_OUT == {$past(PM_DATA_IN[3:0], 4), $past(PM_DATA_IN, 3)}) else $error("bad jump target");
   a_rel_two_cyc:
      assert property (s_fetch ##0 !PM_DATA_IN[7] |=> !INSTR_DONE_OUT ##1 INSTR_DONE_OUT)
         else $error("relative branch not two cycles");
   a_short_internal:
      assert property ((DS_RD_OUT || DS_WR_OUT) |-> DS_ADDR_OUT[7:2] != `CAM_SHORT_BASE)
         else $error("short register on data bus");
   a_strobe_single:
      assert property (DS_WR_OUT |-> !DS_RD_OUT ##1 !DS_WR_OUT) else $error("write strobe overlap");
   a_int_vector:
      assert property (INT_ACK_OUT |-> PC_OUT == $past(INT_VEC_IN)) else $error("interrupt vector not loaded");
endmodule
bind cam_decoder cam_decoder_props i_props (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN),
   .PM_ADDR_OUT(PM_ADDR_OUT), .PM_DATA_IN(PM_DATA_IN), .DS_ADDR_OUT(DS_ADDR_OUT), .DS_RD_OUT(DS_RD_OUT),
   .DS_WR_OUT(DS_WR_OUT), .INT_VEC_IN(INT_VEC_IN), .INT_ACK_OUT(INT_ACK_OUT), .PC_OUT(PC_OUT),
   .CARRY_OUT(CARRY_OUT), .ZERO_OUT(ZERO_OUT), .INSTR_DONE_OUT(INSTR_DONE_OUT));

// *** verif/cam_mem_model.sv ***
// program memory and data space seen by the decoder
// assumes combinational reads and writes on the rising edge
module cam_mem_model (
   // clock
   input wire logic clk_in,
   // program memory
   input wire logic [11:0] pm_addr_in,
   output logic [7:0] pm_data_out,
   // data space
   input wire logic [7:0] ds_addr_in,
   input wire logic ds_rd_in,
   input wire logic ds_wr_in,
   input wire logic [7:0] ds_wdata_in,
   output logic [7:0] ds_rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] pm [0:4095];
   logic [7:0] ds [0:255];
   logic [7:0] last_r;
   // byte after opcode read as is
   assign pm_data_out = pm[pm_addr_in];
   assign ds_rdata_out = ds_rd_in ? ds[ds_addr_in] : ~last_r;
   initial begin
      for (int i = 0; i < 4096; i++) pm[i] = 8'hff;
      for (int i = 0; i < 256; i++) ds[i] = 8'h00;
      last_r = 8'h00;
   end
   // writes land on the edge ending the strobe
   always @(posedge clk_in) begin
      if (ds_rd_in) last_r <= ds[ds_addr_in];
      if (ds_wr_in) ds[ds_addr_in] <= ds_wdata_in;
   end
endmodule

// *** verif/test_cam_decoder.sv ***
// self-checking bench running a small program through the decoder
// assumes the memory model answers every cycle
module test_cam_decoder;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(nm, e, a) begin samples_checked++; if ((a) !== (e)) begin fails++; \
      $display("MISMATCH %s exp %h got %h", nm, e, a); end end
   logic CLOCK_IN = 1'b0;
   logic RST_N_IN = 1'b0;
   logic INT_REQ_IN = 1'b0;
   logic [11:0] INT_VEC_IN = 12'h000;
   logic [11:0] PM_ADDR_OUT, PC_OUT;
   logic [7:0] PM_DATA_IN, DS_ADDR_OUT, DS_WDATA_OUT, DS_RDATA_IN, ACC_OUT;
   logic DS_RD_OUT, DS_WR_OUT, INT_ACK_OUT, CARRY_OUT, ZERO_OUT, INSTR_DONE_OUT;
   int fails = 0;
   int samples_checked = 0;
   int cyc = 0;
   int k;
   logic [11:0] exp_pc[$];
   int exp_cyc[$];
   logic [15:0] seed;
   logic [7:0] n, m;
   always #4 CLOCK_IN = ~CLOCK_IN;
   cam_decoder i_dut (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .PM_ADDR_OUT(PM_ADDR_OUT),
      .PM_DATA_IN(PM_DATA_IN), .DS_ADDR_OUT(DS_ADDR_OUT), .DS_RD_OUT(DS_RD_OUT), .DS_WR_OUT(DS_WR_OUT),
      .DS_WDATA_OUT(DS_WDATA_OUT), .DS_RDATA_IN(DS_RDATA_IN), .INT_REQ_IN(INT_REQ_IN), .INT_VEC_IN(INT_VEC_IN),
      .INT_ACK_OUT(INT_ACK_OUT), .PC_OUT(PC_OUT), .ACC_OUT(ACC_OUT), .CARRY_OUT(CARRY_OUT),
      .ZERO_OUT(ZERO_OUT), .INSTR_DONE_OUT(INSTR_DONE_OUT));
   cam_mem_model i_mem (.clk_in(CLOCK_IN), .pm_addr_in(PM_ADDR_OUT), .pm_data_out(PM_DATA_IN),
      .ds_addr_in(DS_ADDR_OUT), .ds_rd_in(DS_RD_OUT), .ds_wr_in(DS_WR_OUT), .ds_wdata_in(DS_WDATA_OUT),
      .ds_rdata_out(DS_RDATA_IN));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // forward span plus one, backward span
   function automatic logic [11:0] rel_tgt(input logic [11:0] pc, input logic [7:0] op);
      return op[4] ? pc - {8'h00, op[3:0]} : pc + {8'h00, op[3:0]} + 12'h001;
   endfunction
   function automatic logic [11:0] bt_tgt(input logic [11:0] pc, input logic [7:0] d);
      return pc + {{4{d[7]}}, d} + 12'h001;
   endfunction
   task automatic ins(input logic [11:0] a, input logic [23:0] v, input int nb, input logic [11:0] nx,
      input int c);
      for (int j = 0; j < nb; j++) i_mem.pm[a + j] = v[8 * (nb - 1 - j) +: 8];
      exp_pc.push_back(nx);
      exp_cyc.push_back(c);
   endtask
   task automatic wait_for(input int sel, output int cnt);
      cnt = 0;
      do begin
         @(negedge CLOCK_IN);
         cnt++;
      end while ((sel ? INT_ACK_OUT : INSTR_DONE_OUT) !== 1'b1 && cnt < 40);
      if (cnt >= 40) begin
         fails++;
         $display("MISMATCH handshake exp 1 got 0");
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge CLOCK_IN) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         summarize();
      end
   end
   initial begin
      #1;
      seed = lfsr(16'd16955);
      n = seed[7:0] | 8'h01;
      seed = lfsr(seed);
      m = seed[7:0];
      i_mem.ds[8'h30] = m;
      ins(12'h000, 24'h00ca00, 2, 12'h002, 4);
      ins(12'h002, 24'hcb8120, 3, 12'h005, 4);
      ins(12'h005, 24'h00ca5a, 2, 12'h007, 4);
      ins(12'h007, 24'h00c910, 2, 12'h009, 4);
      ins(12'h009, 24'h0000f1, 1, 12'h00a, 4);
      ins(12'h00a, 24'h0000c4, 1, 12'h00b, 4);
      ins(12'h00b, 24'h00ab10, 2, 12'h00d, 4);
      ins(12'h00d, {16'hcb40, n}, 3, 12'h010, 4);
      ins(12'h010, 24'h00c840, 2, 12'h012, 4);
      ins(12'h012, 24'h008300, 2, 12'h300, 4);
      ins(12'h300, 24'h000005, 1, rel_tgt(12'h300, 8'h05), 2);
      ins(12'h306, 24'hbb2080, 3, bt_tgt(12'h306, 8'h80), 5);
      ins(12'h287, 24'h009500, 2, 12'h500, 4);
      ins(12'h500, 24'h0000e8, 1, 12'h289, 2);
      ins(12'h289, 24'h00005f, 1, 12'h28a, 2);
      ins(12'h28a, 24'h00007f, 1, rel_tgt(12'h28a, 8'h7f), 2);
      ins(12'h27b, 24'h00a230, 2, 12'h27d, 4);
      ins(12'h27d, 24'h0000c1, 1, 12'h27e, 4);
      ins(12'h27e, 24'h0000e0, 1, 12'h27f, 4);
      ins(12'h27f, 24'h000022, 1, m[2] ? 12'h280 : rel_tgt(12'h27f, 8'h22), 2);
      repeat (8) @(posedge CLOCK_IN);
      RST_N_IN <= 1'b1;
      for (int i = 0; i < exp_pc.size(); i++) begin
         wait_for(0, k);
         if (i > 0) `CHK("cycles", exp_cyc[i], k)
         `CHK("pc", exp_pc[i], PC_OUT)
         if (i == 1) `CHK("zero", 1'b1, ZERO_OUT)
         if (i == 6) `CHK("carry", 1'b1, CARRY_OUT)
         if (i == 15) `CHK("acc", n, ACC_OUT)
         if (i == 15) `CHK("zero end", 1'b0, ZERO_OUT)
         if (i == 16) `CHK("carry set", m[2], CARRY_OUT)
         if (i == 17) `CHK("short load", 8'h20, ACC_OUT)
         if (i == 18) `CHK("ptr load", 8'h00, ACC_OUT)
         if (i == 18) `CHK("ptr zero", 1'b1, ZERO_OUT)
      end
      `CHK("bit set", m | 8'h04, i_mem.ds[8'h30])
      `CHK("bit clear", 8'h52, i_mem.ds[8'h10])
      `CHK("pointer store", 8'h5a, i_mem.ds[8'h20])
      `CHK("imm store", n, i_mem.ds[8'h40])
      $display("test program done");
      @(posedge CLOCK_IN);
      INT_VEC_IN <= 12'h600;
      INT_REQ_IN <= 1'b1;
      wait_for(1, k);
      `CHK("int pc", 12'h600, PC_OUT)
      @(posedge CLOCK_IN);
      INT_REQ_IN <= 1'b0;
      $display("test interrupt done");
      summarize();
   end
endmodule
